// [pkg/isa_decode_map.svh]
`ifndef ISA_DECODE_MAP_SVH
`define ISA_DECODE_MAP_SVH

// Word geometry.
`define IW_WIDTH 24
`define IW_OPC_HI 23
`define IW_OPC_LO 16
`define IW_OPC_W 8
`define IW_UPPER_ZERO 8'h00

// Opcode assignments (type field values).
`define OPC_SECOND_WORD 8'h00
`define OPC_GOTO_DW 8'h01
`define OPC_CALL_DW 8'h02
`define OPC_MOVE_DW 8'h03
`define OPC_BRANCH 8'h04
`define OPC_BRANCH_COMPUTED 8'h05
`define OPC_CALL_IND 8'h06
`define OPC_GOTO_IND 8'h07
`define OPC_TBL_READ 8'h08
`define OPC_TBL_WRITE 8'h09
`define OPC_RETURN 8'h0a
`define OPC_RETURN_INT 8'h0b
`define OPC_COND_BR_HI 4'h1
`define OPC_SKIP_HI 6'h08
`define OPC_REG3_HI 3'h2
`define OPC_FILE_HI 3'h3
`define OPC_BIT_HI 3'h4
`define OPC_LITALU_HI 3'h5
`define OPC_LITMOV_HI 4'hc

// Register-class fields.
`define F_BASE_HI 15
`define F_BASE_LO 12
`define F_DMODE_HI 11
`define F_DMODE_LO 10
`define F_DREG_HI 9
`define F_DREG_LO 6
`define F_SMODE_HI 5
`define F_SMODE_LO 4
`define F_SREG_HI 3
`define F_SREG_LO 0
// File-class fields.
`define F_DEST_WORKING_REG_ZERO 15
`define F_FADDR_HI 12
// Bit-class fields.
`define F_BIT_FROM_BASE 15
`define F_BIT_USE_FILE 14
`define F_BITPOS_HI 13
`define F_BITPOS_LO 10
`define F_BFADDR_HI 9
// Literal ALU fields.
`define F_HAS_DEST 11
`define F_LDEST_HI 10
`define F_LDEST_LO 7
`define F_LLIT_SHORT_HI 6
`define F_LLIT_LONG_HI 10
// Literal move fields.
`define F_TO_FILE 15
`define F_MLIT_HI 14
`define F_MLIT_LO 4
`define F_MFLIT_HI 14
`define F_MFLIT_LO 8
`define F_MFADDR_HI 7
// Control fields.
`define F_TBL_MODE_HI 1
`define F_ADDR_HI_W 7

// Cycle counts.
`define CYC_ONE 2'd1
`define CYC_TWO 2'd2
`define CYC_THREE 2'd3

`endif

// [pkg/isa_decode_pkg.sv]
`default_nettype none

package isa_decode_pkg;

    typedef enum logic [2:0] {
        CLS_NOP = 3'b000,
        CLS_REG3 = 3'b001,
        CLS_FILE = 3'b010,
        CLS_BIT = 3'b011,
        CLS_LIT_ALU = 3'b100,
        CLS_LIT_MOV = 3'b101,
        CLS_CTRL = 3'b110
    } op_class_t;

    typedef enum logic [2:0] {
        TK_ONE = 3'b000,
        TK_COND = 3'b001,
        TK_TWO = 3'b010,
        TK_THREE = 3'b011,
        TK_SKIP = 3'b100,
        TK_DWORD = 3'b101
    } timing_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DECODE = 3'b001,
        ST_WORD2 = 3'b010,
        ST_SQUASH2 = 3'b011,
        ST_STALL = 3'b100
    } seq_state_t;

    typedef struct packed {
        op_class_t cls;
        timing_kind_t tk;
    } op_info_t;

endpackage
`default_nettype wire

// [logic/opcode_class_rom.sv]
`timescale 1ns/1ns
`default_nettype none
`include "isa_decode_map.svh"

module opcode_class_rom
    import isa_decode_pkg::*;
(
    input wire logic clk_i,
    input wire logic clk_en_i,
    input wire logic [`IW_OPC_W-1:0] opcode_i,
    output op_info_t info_o
);

    function automatic op_info_t lookup(input logic [`IW_OPC_W-1:0] op);
        op_info_t r;
        r = '{cls: CLS_NOP, tk: TK_ONE};
        unique case (op)
            `OPC_GOTO_DW, `OPC_CALL_DW, `OPC_MOVE_DW: r = '{cls: CLS_CTRL, tk: TK_DWORD};
            `OPC_BRANCH, `OPC_BRANCH_COMPUTED, `OPC_CALL_IND, `OPC_GOTO_IND,
            `OPC_TBL_READ, `OPC_TBL_WRITE: r = '{cls: CLS_CTRL, tk: TK_TWO};
            `OPC_RETURN, `OPC_RETURN_INT: r = '{cls: CLS_CTRL, tk: TK_THREE};
            default: begin
                if (op[7:4] == `OPC_COND_BR_HI) begin
                    r = '{cls: CLS_CTRL, tk: TK_COND};
                end else if (op[7:2] == `OPC_SKIP_HI) begin
                    r = '{cls: CLS_BIT, tk: TK_SKIP};
                end else if (op[7:5] == `OPC_REG3_HI) begin
                    r = '{cls: CLS_REG3, tk: TK_ONE};
                end else if (op[7:5] == `OPC_FILE_HI) begin
                    r = '{cls: CLS_FILE, tk: TK_ONE};
                end else if (op[7:5] == `OPC_BIT_HI) begin
                    r = '{cls: CLS_BIT, tk: TK_ONE};
                end else if (op[7:5] == `OPC_LITALU_HI) begin
                    r = '{cls: CLS_LIT_ALU, tk: TK_ONE};
                end else if (op[7:4] == `OPC_LITMOV_HI) begin
                    r = '{cls: CLS_LIT_MOV, tk: TK_ONE};
                end
            end
        endcase
        return r;
    endfunction

    always_ff @(posedge clk_i) begin
        if (clk_en_i) begin
            info_o <= lookup(opcode_i);
        end
    end

endmodule // opcode_class_rom
`default_nettype wire

// [logic/instr_sequencer.sv]
// What this block does
// - Each single word is 24 bits, an 8-bit type field above operand fields.
// - Only three instructions take two program words; all others take one.
// - A double-word instruction is 48 bits and its second word has a zero upper byte.
// - A second word fetched on its own executes as a no-operation.
// - One-word instructions take one cycle, two when a test is true, the PC changes or a table is accessed, three for returns.
// - Branches, indirect call and jump, table accesses and returns take two or three cycles.
// - A taken skip costs two cycles over a one-word target and three over a two-word one.
// - A double-word data move takes two cycles.
// - Every two-word instruction executes in two cycles.
// - Register instructions carry a plain base, a moded source and a moded destination.
// - File instructions carry a file address and a file-or-working-register-zero destination.
// - Bit instructions pick a register or file and take the bit from a literal or the base.
// - Literal arithmetic uses base and literal; a destination appears only if it differs.
// - Literal moves load a register or file; control words carry an address or table mode.
`timescale 1ns/1ns
`default_nettype none
`include "isa_decode_map.svh"

module instr_sequencer
    import isa_decode_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic fetch_valid_i,
    input wire logic [`IW_WIDTH-1:0] fetch_word_i,
    input wire logic cond_true_i,
    output logic fetch_ready_o,
    output logic issue_o,
    output logic no_operation_o,
    output logic word2_bad_o,
    output op_class_t op_class_o,
    output logic [`IW_OPC_W-1:0] opcode_o,
    output logic [1:0] cycles_o,
    output logic [3:0] base_operand_reg_o,
    output logic [3:0] source_operand_reg_o,
    output logic [1:0] source_mode_o,
    output logic [3:0] dest_operand_reg_o,
    output logic [1:0] dest_mode_o,
    output logic use_file_o,
    output logic dest_is_working_reg_zero_o,
    output logic [12:0] file_addr_o,
    output logic [15:0] literal_o,
    output logic [3:0] bit_pos_o,
    output logic bit_from_base_o,
    output logic [22:0] prog_addr_o,
    output logic [1:0] table_mode_o
);

    typedef struct packed {
        seq_state_t st;
        logic [`IW_WIDTH-1:0] ir;
        logic squash;
        logic [1:0] stall;
        logic ready;
        logic issue;
        logic no_operation;
        logic bad;
        op_class_t cls;
        logic [`IW_OPC_W-1:0] opc;
        logic [1:0] cycles;
        logic [3:0] base;
        logic [3:0] sreg;
        logic [1:0] smode;
        logic [3:0] dreg;
        logic [1:0] dmode;
        logic use_file;
        logic dest_working_reg_zero;
        logic [12:0] faddr;
        logic [15:0] lit;
        logic [3:0] bitpos;
        logic bit_base;
        logic [22:0] paddr;
        logic [1:0] tmode;
    } seq_t;

    seq_t cur_ff;
    seq_t nxt_cur;
    op_info_t info;
    logic [15:0] opnd;
    logic [1:0] extra;

    opcode_class_rom u_rom (
        .clk_i(clk_i),
        .clk_en_i(clk_en_i),
        .opcode_i(fetch_word_i[`IW_OPC_HI:`IW_OPC_LO]),
        .info_o(info)
    );

    assign opnd = cur_ff.ir[15:0];

    always_comb begin
        nxt_cur = cur_ff;
        extra = 2'd0;
        nxt_cur.issue = 1'b0;
        nxt_cur.no_operation = 1'b0;
        nxt_cur.bad = 1'b0;
        unique case (cur_ff.st)
            ST_IDLE: begin
                if (fetch_valid_i) begin
                    nxt_cur.ir = fetch_word_i;
                    nxt_cur.st = ST_DECODE;
                    nxt_cur.ready = 1'b0;
                end
            end
            ST_DECODE: begin
                if (cur_ff.squash) begin
                    // Skipped word is burned as a dead cycle.
                    nxt_cur.no_operation = 1'b1;
                    nxt_cur.squash = 1'b0;
                    nxt_cur.st = (info.tk == TK_DWORD) ? ST_SQUASH2 : ST_IDLE;
                    nxt_cur.ready = 1'b1;
                end else if (info.tk == TK_DWORD) begin
                    nxt_cur.st = ST_WORD2;
                    nxt_cur.ready = 1'b1;
                end else begin
                    nxt_cur.issue = 1'b1;
                    nxt_cur.cls = info.cls;
                    nxt_cur.opc = cur_ff.ir[`IW_OPC_HI:`IW_OPC_LO];
                    nxt_cur.no_operation = (info.cls == CLS_NOP);
                    nxt_cur.base = opnd[`F_BASE_HI:`F_BASE_LO];
                    nxt_cur.sreg = opnd[`F_SREG_HI:`F_SREG_LO];
                    nxt_cur.smode = opnd[`F_SMODE_HI:`F_SMODE_LO];
                    nxt_cur.dreg = opnd[`F_DREG_HI:`F_DREG_LO];
                    nxt_cur.dmode = opnd[`F_DMODE_HI:`F_DMODE_LO];
                    nxt_cur.use_file = 1'b0;
                    nxt_cur.dest_working_reg_zero = 1'b0;
                    nxt_cur.faddr = 13'h0000;
                    nxt_cur.lit = 16'h0000;
                    nxt_cur.bitpos = 4'h0;
                    nxt_cur.bit_base = 1'b0;
                    nxt_cur.paddr = 23'h000000;
                    nxt_cur.tmode = 2'h0;
                    unique case (info.cls)
                        CLS_REG3: begin
                            nxt_cur.use_file = 1'b0;
                        end
                        CLS_FILE: begin
                            nxt_cur.use_file = 1'b1;
                            nxt_cur.faddr = opnd[`F_FADDR_HI:0];
                            nxt_cur.dest_working_reg_zero = opnd[`F_DEST_WORKING_REG_ZERO];
                        end
                        CLS_BIT: begin
                            nxt_cur.use_file = opnd[`F_BIT_USE_FILE];
                            nxt_cur.faddr = {3'h0, opnd[`F_BFADDR_HI:0]};
                            nxt_cur.bit_base = opnd[`F_BIT_FROM_BASE];
                            nxt_cur.bitpos = opnd[`F_BITPOS_HI:`F_BITPOS_LO];
                        end
                        CLS_LIT_ALU: begin
                            if (opnd[`F_HAS_DEST]) begin
                                nxt_cur.dreg = opnd[`F_LDEST_HI:`F_LDEST_LO];
                                nxt_cur.lit = {9'h000, opnd[`F_LLIT_SHORT_HI:0]};
                            end else begin
                                nxt_cur.dreg = opnd[`F_BASE_HI:`F_BASE_LO];
                                nxt_cur.lit = {5'h00, opnd[`F_LLIT_LONG_HI:0]};
                            end
                            nxt_cur.dmode = 2'h0;
                        end
                        CLS_LIT_MOV: begin
                            nxt_cur.use_file = opnd[`F_TO_FILE];
                            if (opnd[`F_TO_FILE]) begin
                                nxt_cur.lit = {9'h000, opnd[`F_MFLIT_HI:`F_MFLIT_LO]};
                                nxt_cur.faddr = {5'h00, opnd[`F_MFADDR_HI:0]};
                            end else begin
                                nxt_cur.lit = {5'h00, opnd[`F_MLIT_HI:`F_MLIT_LO]};
                                nxt_cur.dreg = opnd[`F_SREG_HI:`F_SREG_LO];
                            end
                        end
                        CLS_CTRL: begin
                            nxt_cur.base = opnd[`F_SREG_HI:`F_SREG_LO];
                            nxt_cur.tmode = opnd[`F_TBL_MODE_HI:0];
                            nxt_cur.paddr = {7'h00, opnd};
                        end
                        default: begin
                            nxt_cur.use_file = 1'b0;
                        end
                    endcase
                    unique case (info.tk)
                        TK_COND: extra = cond_true_i ? 2'd1 : 2'd0;
                        TK_TWO: extra = 2'd1;
                        TK_THREE: extra = 2'd2;
                        TK_SKIP: nxt_cur.squash = cond_true_i;
                        default: extra = 2'd0;
                    endcase
                    nxt_cur.cycles = `CYC_ONE + extra;
                    nxt_cur.stall = extra;
                    if (extra != 2'd0) begin
                        nxt_cur.st = ST_STALL;
                    end else begin
                        nxt_cur.st = ST_IDLE;
                        nxt_cur.ready = 1'b1;
                    end
                end
            end
            ST_WORD2: begin
                if (fetch_valid_i) begin
                    nxt_cur.issue = 1'b1;
                    nxt_cur.cls = CLS_CTRL;
                    nxt_cur.opc = cur_ff.ir[`IW_OPC_HI:`IW_OPC_LO];
                    nxt_cur.paddr = {fetch_word_i[`F_ADDR_HI_W-1:0], opnd};
                    nxt_cur.lit = opnd;
                    nxt_cur.base = opnd[`F_SREG_HI:`F_SREG_LO];
                    nxt_cur.dreg = fetch_word_i[`F_SREG_HI:`F_SREG_LO];
                    nxt_cur.bad = (fetch_word_i[`IW_OPC_HI:`IW_OPC_LO] != `IW_UPPER_ZERO);
                    nxt_cur.cycles = `CYC_TWO;
                    if (cur_ff.ir[`IW_OPC_HI:`IW_OPC_LO] == `OPC_MOVE_DW) begin
                        nxt_cur.cycles = `CYC_TWO;
                    end
                    nxt_cur.st = ST_IDLE;
                end
            end
            ST_SQUASH2: begin
                if (fetch_valid_i) begin
                    nxt_cur.no_operation = 1'b1;
                    nxt_cur.st = ST_IDLE;
                end
            end
            ST_STALL: begin
                nxt_cur.no_operation = 1'b1;
                nxt_cur.stall = cur_ff.stall - 2'd1;
                if (cur_ff.stall == 2'd1) begin
                    nxt_cur.st = ST_IDLE;
                    nxt_cur.ready = 1'b1;
                end
            end
            default: begin
                nxt_cur.st = ST_IDLE;
                nxt_cur.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cur_ff <= '0;
            cur_ff.st <= ST_IDLE;
            cur_ff.ready <= 1'b1;
        end else if (clk_en_i) begin
            cur_ff <= nxt_cur;
        end
    end

    assign fetch_ready_o = cur_ff.ready;
    assign issue_o = cur_ff.issue;
    assign no_operation_o = cur_ff.no_operation;
    assign word2_bad_o = cur_ff.bad;
    assign op_class_o = cur_ff.cls;
    assign opcode_o = cur_ff.opc;
    assign cycles_o = cur_ff.cycles;
    assign base_operand_reg_o = cur_ff.base;
    assign source_operand_reg_o = cur_ff.sreg;
    assign source_mode_o = cur_ff.smode;
    assign dest_operand_reg_o = cur_ff.dreg;
    assign dest_mode_o = cur_ff.dmode;
    assign use_file_o = cur_ff.use_file;
    assign dest_is_working_reg_zero_o = cur_ff.dest_working_reg_zero;
    assign file_addr_o = cur_ff.faddr;
    assign literal_o = cur_ff.lit;
    assign bit_pos_o = cur_ff.bitpos;
    assign bit_from_base_o = cur_ff.bit_base;
    assign prog_addr_o = cur_ff.paddr;
    assign table_mode_o = cur_ff.tmode;

endmodule // instr_sequencer
`default_nettype wire

// [dv/cpu_timing_chk.sv]
`timescale 1ns/1ns
`default_nettype none
`include "isa_decode_map.svh"

module cpu_timing_chk
    import isa_decode_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic cond_true_i,
    input wire logic fetch_ready_o,
    input wire logic issue_o,
    input wire logic no_operation_o,
    input wire logic word2_bad_o,
    input wire op_class_t op_class_o,
    input wire logic [`IW_OPC_W-1:0] opcode_o,
    input wire logic [1:0] cycles_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic dword;
    assign dword = opcode_o inside {`OPC_GOTO_DW, `OPC_CALL_DW, `OPC_MOVE_DW};
    sequence two_dead_s;
        issue_o && clk_en_i && cycles_o == `CYC_TWO && !dword;
    endsequence
    sequence three_dead_s;
        issue_o && clk_en_i && cycles_o == `CYC_THREE;
    endsequence
    cyc_range_a: assert property (issue_o |-> cycles_o inside {1, 2, 3})
        else $error("cycle count out of range");
    ret_three_a: assert property (issue_o && opcode_o inside {8'h0a, 8'h0b} |-> cycles_o == 3)
        else $error("return not three cycles");
    dword_two_a: assert property (issue_o && dword |-> cycles_o == `CYC_TWO)
        else $error("double word not two cycles");
    nop_word_a: assert property (issue_o && opcode_o == `OPC_SECOND_WORD |-> no_operation_o)
        else $error("lone second word not a no-operation");
    dead_ready_a: assert property (issue_o && cycles_o != 2'd1 && !dword |-> !fetch_ready_o)
        else $error("fetch open during extra cycle");
    one_ready_a: assert property (issue_o && cycles_o == 2'd1 |-> fetch_ready_o)
        else $error("fetch closed after one-cycle issue");
    pulse_once_a: assert property (issue_o && clk_en_i |=> !issue_o)
        else $error("issue longer than one cycle");
    two_dead_a: assert property (two_dead_s |=> no_operation_o && !issue_o)
        else $error("missing dead cycle");
    three_dead_a: assert property (three_dead_s |=> no_operation_o && !fetch_ready_o)
        else $error("missing first of two dead cycles");
    cond_cost_a: assert property (issue_o && opcode_o[7:4] == 4'h1 |-> cycles_o == (cond_true_i ? 2 : 1))
        else $error("conditional branch cost wrong");
    bad_word_a: assert property (word2_bad_o |-> issue_o && dword)
        else $error("second word flag outside double word");
    nop_class_a: assert property (issue_o |-> no_operation_o == (op_class_o == CLS_NOP))
        else $error("dead flag disagrees with issued class");
endmodule // cpu_timing_chk
`default_nettype wire

// [dv/prog_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none

module prog_mem_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic ready_i,
    input wire logic stall_i,
    output logic valid_o,
    output logic [23:0] word_o,
    output logic cond_o
);
    logic [24:0] mem [0:255];
    int n = 0;
    int ptr = 0;
    logic [23:0] last_q;
    logic take;
    assign take = clk_en_i && valid_o && ready_i;
    // An idle bus shows the inverse of the last word so stale data never matches.
    assign word_o = valid_o ? mem[ptr][23:0] : ~last_q;
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            ptr <= 0;
            valid_o <= 1'b0;
            last_q <= 24'h000000;
            cond_o <= 1'b0;
        end else if (take) begin
            ptr <= ptr + 1;
            last_q <= word_o;
            cond_o <= mem[ptr][24];
            valid_o <= (ptr + 1 < n) && !stall_i;
        end else if (!valid_o) begin
            valid_o <= (ptr < n) && !stall_i;
        end
    end
endmodule // prog_mem_model
`default_nettype wire

// [dv/tb_cpu_instruction_format_timing.sv]
`timescale 1ns/1ns
`default_nettype none
`include "isa_decode_map.svh"

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_cpu_instruction_format_timing
    import isa_decode_pkg::*;
;
    typedef struct {int w; int w2; int cyc;} exp_t;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic stall = 1'b0;
    logic fetch_valid, cond_true, fetch_ready_o, issue_o, no_operation_o, word2_bad_o;
    logic use_file_o, dest_is_working_reg_zero_o, bit_from_base_o;
    logic [23:0] fetch_word;
    op_class_t op_class_o;
    logic [7:0] opcode_o;
    logic [1:0] cycles_o, source_mode_o, dest_mode_o, table_mode_o;
    logic [3:0] base_operand_reg_o, source_operand_reg_o, dest_operand_reg_o, bit_pos_o;
    logic [12:0] file_addr_o;
    logic [22:0] prog_addr_o;
    logic [15:0] reg3_f, literal_o;
    int seed = 46;
    int err_total = 0;
    int total_checks = 0;
    int cycle_count = 0;
    int nop_seen = 0;
    int exp_nops = 0;
    int n = 0;
    int wd [256];
    int cd [256];
    exp_t exp_q [$];
    int tbl [30] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
        8'h0a, 8'h0b, 8'h0c, 8'h10, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h5f, 8'h60,
        8'h7f, 8'h80, 8'h9f, 8'ha0, 8'hbf, 8'hc0, 8'hcf, 8'he5};
    assign reg3_f = {base_operand_reg_o, dest_mode_o, dest_operand_reg_o, source_mode_o,
        source_operand_reg_o};

    instr_sequencer instr_sequencer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i), .fetch_valid_i(fetch_valid), .fetch_word_i(fetch_word),
        .cond_true_i(cond_true), .fetch_ready_o(fetch_ready_o), .issue_o(issue_o),
        .no_operation_o(no_operation_o), .word2_bad_o(word2_bad_o), .op_class_o(op_class_o),
        .opcode_o(opcode_o), .cycles_o(cycles_o), .base_operand_reg_o(base_operand_reg_o),
        .source_operand_reg_o(source_operand_reg_o), .source_mode_o(source_mode_o),
        .dest_operand_reg_o(dest_operand_reg_o), .dest_mode_o(dest_mode_o),
        .use_file_o(use_file_o), .dest_is_working_reg_zero_o(dest_is_working_reg_zero_o),
        .file_addr_o(file_addr_o), .literal_o(literal_o), .bit_pos_o(bit_pos_o),
        .bit_from_base_o(bit_from_base_o), .prog_addr_o(prog_addr_o),
        .table_mode_o(table_mode_o));

    prog_mem_model prog_mem_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i), .ready_i(fetch_ready_o), .stall_i(stall),
        .valid_o(fetch_valid), .word_o(fetch_word), .cond_o(cond_true));

    function automatic int cls_of(int op);
        if (op >= 8'hd0 || op == 0 || op inside {[8'h0c:8'h0f], [8'h24:8'h3f]}) return CLS_NOP;
        if (op >= 8'hc0) return CLS_LIT_MOV;
        if (op >= 8'ha0) return CLS_LIT_ALU;
        if (op >= 8'h80) return CLS_BIT;
        if (op >= 8'h60) return CLS_FILE;
        if (op >= 8'h40) return CLS_REG3;
        return -1;
    endfunction

    function automatic int cyc_of(int op, int c);
        if (op inside {[1:9]}) return 2;
        if (op inside {10, 11}) return 3;
        if (op inside {[8'h10:8'h1f]}) return c ? 2 : 1;
        return 1;
    endfunction

    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycle_count <= cycle_count + 1;
        clk_en_i <= sys_rst_i || ($random(seed) & 7) != 0;
        stall <= ($random(seed) & 3) == 0;
        if (cycle_count == 20000) begin
            err_total++;
            complete_run();
        end
    end

    // Each pulse is counted at the enabled edge that consumes it.
    always @(posedge clk_i) begin
        exp_t e;
        int c;
        logic [15:0] f, xl;
        logic [3:0] xd;
        if (!sys_rst_i && clk_en_i) begin
            nop_seen += (no_operation_o === 1'b1);
            if (issue_o === 1'b1) begin
                if (exp_q.size() == 0) `CHK(issue_o, 1'b0)
                else begin
                    e = exp_q.pop_front();
                    c = cls_of(e.w >> 16);
                    f = e.w[15:0];
                    xd = f[11] ? f[10:7] : f[15:12];
                    xl = f[11] ? {9'h000, f[6:0]} : {5'h00, f[10:0]};
                    if (c == CLS_LIT_MOV) xl = f[15] ? {9'h000, f[14:8]} : {5'h00, f[14:4]};
                    `CHK(opcode_o, e.w[23:16])
                    `CHK(cycles_o, e.cyc[1:0])
                    if (c >= 0) `CHK(op_class_o, c[2:0])
                    if (c == CLS_NOP) `CHK(no_operation_o, 1'b1)
                    if (c == CLS_REG3) `CHK(reg3_f, e.w[15:0])
                    if (c == CLS_FILE) `CHK({dest_is_working_reg_zero_o, file_addr_o}, {e.w[15], e.w[12:0]})
                    if (c == CLS_BIT) `CHK({bit_from_base_o, use_file_o, bit_pos_o}, e.w[15:10])
                    `CHK(word2_bad_o, e.w[23:16] inside {[1:3]} && e.w2[23:16] != 0)
                    if (e.w[23:16] inside {[1:3]}) `CHK(prog_addr_o, {e.w2[6:0], e.w[15:0]})
                    if (e.w[23:16] inside {[1:3]}) `CHK(literal_o, f)
                    if (e.w[23:16] inside {[1:3]}) `CHK(dest_operand_reg_o, e.w2[3:0])
                    if (e.w[23:16] inside {[4:11], [16:31]}) `CHK(table_mode_o, f[1:0])
                    if (e.w[23:16] inside {[4:11], [16:31]}) `CHK(prog_addr_o, f)
                    if (c inside {CLS_LIT_ALU, CLS_LIT_MOV}) `CHK(literal_o, xl)
                    if (c == CLS_LIT_ALU) `CHK(base_operand_reg_o, f[15:12])
                    if (c == CLS_LIT_ALU) `CHK(dest_operand_reg_o, xd)
                    if (c == CLS_LIT_MOV) `CHK(use_file_o, f[15])
                    if (c == CLS_LIT_MOV && f[15]) `CHK(file_addr_o, f[7:0])
                    if (c == CLS_LIT_MOV && !f[15]) `CHK(dest_operand_reg_o, f[3:0])
                end
            end
        end
    end

    initial begin
        int op, k, i, s;
        exp_t e;
        k = 0;
        while (n < 240) begin
            op = k < 30 ? tbl[k] : tbl[$unsigned($random(seed)) % 30];
            k++;
            wd[n] = (op << 16) | ($random(seed) & 32'h0000ffff);
            cd[n] = $random(seed) & 1;
            n++;
            if (op inside {[1:3]}) begin
                wd[n] = ((($random(seed) & 3) == 0) ? 32'h005a0000 : 0) | ($random(seed) & 32'h0000ffff);
                cd[n] = 0;
                n++;
            end
        end
        repeat (2) begin
            wd[n] = 32'h00401234;
            cd[n] = 0;
            n++;
        end
        i = 0;
        while (i < n) begin
            op = wd[i] >> 16;
            e.w = wd[i];
            e.w2 = wd[i + 1];
            e.cyc = cyc_of(op, cd[i]);
            exp_q.push_back(e);
            i++;
            if (op inside {[1:3]}) i++;
            else exp_nops += e.cyc - 1 + (cls_of(op) == CLS_NOP);
            if (op inside {[8'h20:8'h23]} && cd[i - 1] != 0) begin
                s = ((wd[i] >> 16) inside {[1:3]}) ? 2 : 1;
                exp_nops += s;
                i += s;
            end
        end
        for (i = 0; i < n; i++) prog_mem_model_inst.mem[i] = {cd[i][0], wd[i][23:0]};
        prog_mem_model_inst.n = n;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        while (prog_mem_model_inst.ptr < n) @(posedge clk_i);
        repeat (12) @(posedge clk_i);
        `CHK(nop_seen, exp_nops)
        `CHK(exp_q.size(), 0)
        complete_run();
    end
endmodule // tb_cpu_instruction_format_timing

bind instr_sequencer cpu_timing_chk cpu_timing_chk_inst (.clk_i, .sys_rst_i, .clk_en_i,
    .cond_true_i, .fetch_ready_o, .issue_o, .no_operation_o, .word2_bad_o, .op_class_o,
    .opcode_o, .cycles_o);
`default_nettype wire
